/* rtl/pm_regs_pkg.sv */
// Purpose: constants and carriers for the function power-state registers
// Assumes: byte offsets within the power capability item
// Notes: Notes on behaviour list below
//
// Notes on behaviour
// RULE1: wake request sets flag regardless of enable
// RULE2: write one clears flag, zero ignored
// RULE3: sticky flag/enable survive power-on and cold return
// RULE4: cold-capable function keeps wake context on bus reset
// RULE5: otherwise bus reset zeroes flag and enable
// RULE6: software clears enable, flag at OS load
// RULE7: enable gates the wake pin output
// RULE8: no wake support makes enable read zero
// RULE9: scale field reads readout scale, else zero
// RULE10: selector resets zero, read-only zero without readout
// RULE11: power-state field resets D0, reads current state
// RULE12: unsupported state writes dropped, bus completes
// RULE13: skip bit set keeps context on hot-to-D0
// RULE14: skip bit clear pulses internal reset on hot-to-D0
// RULE15: bus reset always lands uninitialized D0
// RULE16: bridge control bit zero blocks bus control
// RULE17: bridge action bit picks clock stop or power off
// RULE18: readout returns selected value, else zero
// RULE19: readout implies selector and scale fields
// RULE20: software scans 16 selector values for presence
// RULE21: software selects, reads scale and data, multiplies
// RULE22: function 0 selector 1000b reports shared logic
// RULE23: byte, word and doubleword accesses accepted
// RULE24: wake context in aux domain with own reset
package pm_regs_pkg;
    // ========================================
    // offsets
    localparam logic [7:0] OFS_CTRL_STATUS = 8'h04;
    localparam logic [7:0] OFS_BRIDGE_EXT = 8'h06;
    localparam logic [7:0] OFS_READOUT = 8'h07;
    localparam logic [7:0] OFS_DWORD_MASK = 8'hfc;
    // ========================================
    // field positions
    localparam int WAKE_FLAG_BIT = 15;
    localparam int SCALE_LSB = 13;
    localparam int SELECT_LSB = 9;
    localparam int WAKE_EN_BIT = 8;
    localparam int SKIP_RESET_BIT = 3;
    localparam int BUS_CTL_EN_BIT = 7;
    localparam int BUS_ACTION_BIT = 6;
    localparam logic [3:0] SHARED_SELECT = 4'h8;
    // ========================================
    // reset values
    localparam logic [3:0] SELECT_RESET = 4'h0;
    localparam logic [7:0] READOUT_ABSENT = 8'h00;
    typedef enum logic [1:0] {
        STATE_D0 = 2'h0,
        STATE_D1 = 2'h1,
        STATE_D2 = 2'h2,
        STATE_D3HOT = 2'h3
    } power_state_e;
    typedef enum logic [1:0] {
        BUS_ON,
        BUS_CLOCK_STOP,
        BUS_POWER_OFF
    } bus_action_e;
    // one configuration access
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [3:0] byteEn;
        logic [31:0] wdata;
    } cfg_req_s;
endpackage

/* rtl/function_power_state_regs.sv */
// Purpose: power control/status, bridge extension and readout registers
// Assumes: dword config access, byte enables per lane, one-cycle read data
// Notes: wake context cleared by aux domain reset, kept on bus reset if cold-capable
`timescale 1ns/100ps
module function_power_state_regs #(
    parameter logic [4:0] WAKE_SUPPORT = 5'h1f,
    parameter bit D1_SUPPORT = 1'b1,
    parameter bit D2_SUPPORT = 1'b1,
    parameter bit SKIP_INTERNAL_RESET = 1'b0,
    parameter bit HAS_READOUT = 1'b1,
    parameter bit IS_FUNC0_MULTI = 1'b0,
    parameter bit IS_BRIDGE = 1'b0
) (
    // clock and resets
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic auxPorRst_n,
    // configuration access
    input wire pm_regs_pkg::cfg_req_s cfgReq,
    output logic [31:0] cfgRdata,
    output logic cfgAck,
    // wake source and pin
    input wire logic wakeRequest,
    output logic wakePinDrive,
    // readout table per selector, scale per selector
    input wire logic [15:0][7:0] readoutTable,
    input wire logic [15:0][1:0] scaleTable,
    // bridge straps
    input wire logic busCtlEnStrap,
    input wire logic busActionStrap,
    // power outputs
    output pm_regs_pkg::power_state_e power_state_field,
    output logic internalResetPulse,
    output pm_regs_pkg::bus_action_e secondaryBusAction
);
    import pm_regs_pkg::*;

    // ========================================
    // decode
    localparam bit COLD_WAKE = WAKE_SUPPORT[4];
    logic hitDword;
    logic wrLow;
    logic wrHigh;
    logic [15:0] wdLow;
    assign hitDword = (cfgReq.addr & OFS_DWORD_MASK) == OFS_CTRL_STATUS;
    // byte lanes allow byte, word and dword sizes
    assign wrLow = cfgReq.wr && hitDword && cfgReq.byteEn[0]; // RULE23
    assign wrHigh = cfgReq.wr && hitDword && cfgReq.byteEn[1]; // RULE23
    assign wdLow = cfgReq.wdata[15:0];
    assign cfgAck = cfgReq.rd | cfgReq.wr; // RULE12

    function automatic logic stateOk(input logic [1:0] s);
        unique case (s)
            STATE_D1: stateOk = D1_SUPPORT;
            STATE_D2: stateOk = D2_SUPPORT;
            default: stateOk = 1'b1;
        endcase
    endfunction

    // ========================================
    // wake context, aux domain
    logic wakeFlag;
    logic wakeEn;
    logic next_wakeFlag;
    logic next_wakeEn;
    logic wakeRst;
    // cold-capable: only aux power-on reset clears; else bus reset too
    assign wakeRst = !auxPorRst_n || (!COLD_WAKE && !rst_n); // RULE3 RULE4 RULE5 RULE24
    always_comb begin
        next_wakeFlag = wakeFlag;
        next_wakeEn = wakeEn;
        if (wrHigh && cfgReq.wdata[WAKE_FLAG_BIT]) begin
            next_wakeFlag = 1'b0; // RULE2
        end
        if (wakeRequest) begin
            next_wakeFlag = 1'b1; // RULE1
        end
        if (wrHigh) begin
            next_wakeEn = (WAKE_SUPPORT != 5'h00) &&
                cfgReq.wdata[WAKE_EN_BIT]; // RULE7 RULE8
        end
    end
    always_ff @(posedge core_clk) begin
        if (wakeRst) begin
            wakeFlag <= 1'b0;
            wakeEn <= 1'b0;
        end else begin
            wakeFlag <= next_wakeFlag;
            wakeEn <= next_wakeEn;
        end
    end
    // pin driven while pending and enabled
    assign wakePinDrive = wakeFlag && wakeEn; // RULE7 RULE2

    // ========================================
    // power state and selector
    logic [3:0] select;
    logic [3:0] next_select;
    power_state_e next_power_state_field;
    logic next_internalResetPulse;
    always_comb begin
        next_select = select;
        next_power_state_field = power_state_field;
        next_internalResetPulse = 1'b0;
        if (wrHigh && HAS_READOUT) begin
            next_select = cfgReq.wdata[SELECT_LSB +: 4]; // RULE10 RULE19
        end
        if (wrLow && stateOk(wdLow[1:0])) begin // RULE12
            next_power_state_field = power_state_e'(wdLow[1:0]); // RULE11
            if (power_state_field == STATE_D3HOT &&
                wdLow[1:0] == STATE_D0 && !SKIP_INTERNAL_RESET) begin
                next_internalResetPulse = 1'b1; // RULE14
            end
        end
    end
    // soft reset also clears selector; skip bit keeps it
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            power_state_field <= STATE_D0; // RULE15
            select <= SELECT_RESET; // RULE10
            internalResetPulse <= 1'b0;
        end else begin
            power_state_field <= next_power_state_field;
            select <= internalResetPulse ? SELECT_RESET : next_select; // RULE13
            internalResetPulse <= next_internalResetPulse;
        end
    end

    // ========================================
    // bridge secondary bus
    always_comb begin
        secondaryBusAction = BUS_ON;
        if (IS_BRIDGE && busCtlEnStrap &&
            power_state_field == STATE_D3HOT) begin // RULE16
            secondaryBusAction = busActionStrap ? BUS_CLOCK_STOP
                : BUS_POWER_OFF; // RULE17
        end
    end

    // ========================================
    // readout
    logic [7:0] readout;
    logic [1:0] scale;
    always_comb begin
        readout = READOUT_ABSENT;
        scale = 2'h0;
        if (HAS_READOUT) begin
            // index 8 in function 0 is shared logic, else reserved
            if (select < SHARED_SELECT ||
                (select == SHARED_SELECT && IS_FUNC0_MULTI)) begin // RULE22
                readout = readoutTable[select]; // RULE18
                scale = scaleTable[select]; // RULE9
            end
        end
    end

    // ========================================
    // read data
    logic [31:0] next_cfgRdata;
    always_comb begin
        next_cfgRdata = 32'h0;
        if (cfgReq.rd && hitDword) begin
            next_cfgRdata[WAKE_FLAG_BIT] = wakeFlag;
            next_cfgRdata[SCALE_LSB +: 2] = scale;
            next_cfgRdata[SELECT_LSB +: 4] = select;
            next_cfgRdata[WAKE_EN_BIT] = wakeEn;
            next_cfgRdata[SKIP_RESET_BIT] = SKIP_INTERNAL_RESET; // RULE13
            next_cfgRdata[1:0] = power_state_field; // RULE11
            next_cfgRdata[16 + BUS_CTL_EN_BIT] = IS_BRIDGE && busCtlEnStrap;
            next_cfgRdata[16 + BUS_ACTION_BIT] = IS_BRIDGE && busActionStrap;
            next_cfgRdata[31:24] = readout;
        end
    end
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cfgRdata <= 32'h0;
        end else begin
            cfgRdata <= next_cfgRdata;
        end
    end

    // ========================================
    // checks
    AST_FLAG_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
        wakeRequest && auxPorRst_n |=> wakeFlag) // RULE1
        else $error("wake flag not set");
    AST_FLAG_CLR: assert property (@(posedge core_clk) disable iff (!rst_n)
        wrHigh && cfgReq.wdata[15] && !wakeRequest && auxPorRst_n
        |=> !wakeFlag && !wakePinDrive) // RULE2
        else $error("wake flag not cleared");
    AST_FLAG_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
        wrHigh && !cfgReq.wdata[15] && wakeFlag && auxPorRst_n
        |=> wakeFlag) // RULE2
        else $error("zero write changed flag");
    AST_PIN_GATE: assert property (@(posedge core_clk) disable iff (!rst_n)
        wakePinDrive |-> wakeEn && wakeFlag) // RULE7
        else $error("pin driven without enable");
    AST_BAD_STATE: assert property (@(posedge core_clk) disable iff (!rst_n)
        wrLow && !stateOk(wdLow[1:0]) |=> $stable(power_state_field)) // RULE12
        else $error("unsupported state taken");
    AST_SOFT_RST: assert property (@(posedge core_clk) disable iff (!rst_n)
        wrLow && power_state_field == STATE_D3HOT && wdLow[1:0] == 2'h0
        |=> internalResetPulse == !SKIP_INTERNAL_RESET
        ##1 !internalResetPulse) // RULE13 RULE14
        else $error("soft reset wrong");
    AST_STATE_RST: assert property (@(posedge core_clk)
        !rst_n |=> power_state_field == STATE_D0 && select == 4'h0) // RULE15
        else $error("bus reset did not land D0");
    AST_NO_READOUT: assert property (@(posedge core_clk) disable iff (!rst_n)
        !HAS_READOUT |-> select == 4'h0 && readout == 8'h0
        && scale == 2'h0) // RULE9
        else $error("absent readout nonzero");
    AST_BUS_CTL: assert property (@(posedge core_clk) disable iff (!rst_n)
        !busCtlEnStrap |-> secondaryBusAction == BUS_ON) // RULE16
        else $error("bus action without enable");
    AST_WAKE_KEEP: assert property (@(posedge core_clk)
        COLD_WAKE && !rst_n && auxPorRst_n && !wakeRequest && !wrHigh
        && wakeFlag |=> wakeFlag) // RULE4
        else $error("bus reset lost wake context");
    // ========================================
    // read-back checks, data lands one cycle after the read
    logic [1:0] reqState;
    logic [3:0] reqSelect;
    logic rdHit;
    assign reqState = wdLow[1:0];
    assign reqSelect = cfgReq.wdata[SELECT_LSB +: 4];
    assign rdHit = cfgReq.rd && hitDword;
    AST_STATE_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
        rdHit |=> cfgRdata[1:0] == $past(power_state_field)) // RULE11
        else $error("state read back wrong");
    AST_FLAG_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
        rdHit |=> cfgRdata[15] == $past(wakeFlag)) // RULE1
        else $error("flag read back wrong");
    AST_EN_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
        rdHit |=> cfgRdata[8] == $past(wakeEn)) // RULE7
        else $error("enable read back wrong");
    AST_SELECT_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
        rdHit |=> cfgRdata[12:9] == $past(select)) // RULE10
        else $error("selector read back wrong");
    AST_SCALE_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
        rdHit |=> cfgRdata[14:13] == $past(scale)) // RULE9
        else $error("scale read back wrong");
    AST_DATA_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
        rdHit |=> cfgRdata[31:24] == $past(readout)) // RULE18
        else $error("readout read back wrong");
    AST_SKIP_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
        rdHit |=> cfgRdata[3] == SKIP_INTERNAL_RESET) // RULE13
        else $error("skip bit read back wrong");
    AST_RSVD_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
        rdHit |=> cfgRdata[7:4] == 4'h0 && !cfgRdata[2]
        && cfgRdata[21:16] == 6'h00) // RULE23
        else $error("reserved bits nonzero");
    AST_MISS_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
        !rdHit |=> cfgRdata == 32'h0) // RULE23
        else $error("read data without hit");
    AST_BRIDGE_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
        !IS_BRIDGE && rdHit |=> cfgRdata[23:22] == 2'h0) // RULE16
        else $error("bridge bits in non-bridge");
    // ========================================
    // state, wake and bridge checks
    AST_STATE_TAKE: assert property (@(posedge core_clk) disable iff (!rst_n)
        wrLow && stateOk(reqState)
        |=> power_state_field == $past(reqState)) // RULE11
        else $error("supported state not taken");
    AST_SELECT_TAKE: assert property (@(posedge core_clk) disable iff (!rst_n)
        wrHigh && HAS_READOUT && !internalResetPulse
        |=> select == $past(reqSelect)) // RULE10
        else $error("selector write not taken");
    AST_NOSEL_WR: assert property (@(posedge core_clk) disable iff (!rst_n)
        !HAS_READOUT && wrHigh |=> select == 4'h0) // RULE10
        else $error("selector written without readout");
    AST_PULSE_SRC: assert property (@(posedge core_clk) disable iff (!rst_n)
        internalResetPulse |-> power_state_field == STATE_D0
        && $past(power_state_field) == STATE_D3HOT) // RULE14
        else $error("internal reset without hot exit");
    AST_NO_PULSE: assert property (@(posedge core_clk) disable iff (!rst_n)
        SKIP_INTERNAL_RESET |-> !internalResetPulse) // RULE13
        else $error("internal reset with skip set");
    AST_ACK: assert property (@(posedge core_clk) disable iff (!rst_n)
        cfgReq.rd || cfgReq.wr |-> cfgAck) // RULE12
        else $error("access not acknowledged");
    AST_AUX_CLR: assert property (@(posedge core_clk)
        !auxPorRst_n |=> !wakeFlag && !wakeEn) // RULE24
        else $error("aux reset kept wake bits");
    AST_BUS_CLR: assert property (@(posedge core_clk)
        !COLD_WAKE && !rst_n |=> !wakeFlag && !wakeEn) // RULE5
        else $error("bus reset kept wake bits");
    AST_EN_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
        WAKE_SUPPORT == 5'h00 |-> !wakeEn) // RULE8
        else $error("enable set without wake support");
    AST_CLOCK_STOP: assert property (@(posedge core_clk) disable iff (!rst_n)
        IS_BRIDGE && busCtlEnStrap && busActionStrap
        && power_state_field == STATE_D3HOT |-> secondaryBusAction == BUS_CLOCK_STOP)
        else $error("secondary clock not stopped"); // RULE17
    AST_POWER_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
        IS_BRIDGE && busCtlEnStrap && !busActionStrap
        && power_state_field == STATE_D3HOT |-> secondaryBusAction == BUS_POWER_OFF)
        else $error("secondary power not removed"); // RULE17
    AST_SHARED_SEL: assert property (@(posedge core_clk) disable iff (!rst_n)
        select == SHARED_SELECT && !IS_FUNC0_MULTI
        |-> readout == 8'h0 && scale == 2'h0) // RULE22
        else $error("shared readout outside function 0");
    AST_RSVD_SEL: assert property (@(posedge core_clk) disable iff (!rst_n)
        select > SHARED_SELECT |-> readout == 8'h0 && scale == 2'h0) // RULE22
        else $error("reserved selector nonzero");
    AST_COLD_EN: assert property (@(posedge core_clk)
        COLD_WAKE && !rst_n && auxPorRst_n && !wrHigh && wakeEn
        |=> wakeEn) // RULE3
        else $error("bus reset lost wake enable");
endmodule

/* tb/cfg_host_model.sv */
// Purpose: host side issuing configuration accesses
// Assumes: one access at a time, request held for one clock, ack not waited on
// Notes: release comes on the edge that takes it
`timescale 1ns/100ps
module cfg_host_model (
    // clock
    input wire logic core_clk,
    // access port
    output pm_regs_pkg::cfg_req_s cfgReq,
    input wire logic [31:0] cfgRdata,
    input wire logic cfgAck
);
    import pm_regs_pkg::*;
    initial cfgReq = '0;
    // ========================================
    // access tasks
    task automatic wr(input logic [7:0] a, input logic [3:0] be,
                      input logic [31:0] d, output logic ack);
        @(posedge core_clk);
        cfgReq <= '{rd: 1'b0, wr: 1'b1, addr: a, byteEn: be, wdata: d};
        #1 ack = cfgAck;
        @(posedge core_clk);
        cfgReq <= '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        cfgReq <= '{rd: 1'b1, wr: 1'b0, addr: a, byteEn: 4'hf, wdata: '0};
        @(posedge core_clk);
        cfgReq <= '0;
        #1 d = cfgRdata;
    endtask
endmodule

/* tb/function_power_state_regs_bench.sv */
// Purpose: self-checking bench for the power-state registers
// Assumes: D2 absent, bridge, function 0 of a multi-function part
// Notes: expectations kept in a small shadow of the fields
`timescale 1ns/100ps
module function_power_state_regs_bench;
    import pm_regs_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic auxPorRst_n = 1'b0;
    cfg_req_s cfgReq;
    logic [31:0] cfgRdata;
    logic [31:0] rdat;
    logic [31:0] n;
    logic cfgAck;
    logic ack;
    logic wakeRequest = 1'b0;
    logic wakePinDrive;
    logic [15:0][7:0] readoutTable;
    logic [15:0][1:0] scaleTable;
    logic busCtlEnStrap = 1'b1;
    logic busActionStrap = 1'b1;
    power_state_e power_state_field;
    logic internalResetPulse;
    bus_action_e secondaryBusAction;
    logic fl, en;
    logic [3:0] sel;
    logic [1:0] st;
    int error_cnt = 0;
    int compares = 0;
    always #2 core_clk = ~core_clk;
    function_power_state_regs #(.D2_SUPPORT(1'b0), .IS_FUNC0_MULTI(1'b1),
        .IS_BRIDGE(1'b1)) function_power_state_regs_i (
        .core_clk(core_clk), .rst_n(rst_n), .auxPorRst_n(auxPorRst_n),
        .cfgReq(cfgReq), .cfgRdata(cfgRdata), .cfgAck(cfgAck),
        .wakeRequest(wakeRequest), .wakePinDrive(wakePinDrive),
        .readoutTable(readoutTable), .scaleTable(scaleTable),
        .busCtlEnStrap(busCtlEnStrap), .busActionStrap(busActionStrap),
        .power_state_field(power_state_field), .internalResetPulse(internalResetPulse),
        .secondaryBusAction(secondaryBusAction));
    cfg_host_model cfg_host_model_i (.core_clk(core_clk), .cfgReq(cfgReq),
        .cfgRdata(cfgRdata), .cfgAck(cfgAck));
    // ========================================
    // helpers
    task automatic close_out();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
        compares++;
        if (s !== e) begin
            $display("CHECK FAILED %s exp %h got %h", nm, e, s);
            error_cnt++;
        end
    endtask
    function automatic logic [31:0] wd(logic f, logic e, logic [1:0] p);
        return {16'h0, f, 2'h0, sel, e, 6'h00, p};
    endfunction
    // reserved selectors beyond 8 read zero
    function automatic logic [31:0] expv();
        logic [7:0] ro;
        logic [1:0] sc;
        ro = (sel <= 4'h8) ? readoutTable[sel] : 8'h00;
        sc = (sel <= 4'h8) ? scaleTable[sel] : 2'h0;
        return {ro, busCtlEnStrap, busActionStrap, 6'h00,
                fl, sc, sel, en, 6'h00, st};
    endfunction
    task automatic w(logic [3:0] be, logic [31:0] d);
        cfg_host_model_i.wr(8'h04, be, d, ack);
        chk("ack", 1, ack);
    endtask
    task automatic rchk(string nm);
        cfg_host_model_i.rd(8'h04, rdat);
        chk(nm, expv(), rdat);
    endtask
    task automatic pulse_rst(bit aux);
        @(posedge core_clk);
        if (aux) auxPorRst_n <= 1'b0; else rst_n <= 1'b0;
        @(posedge core_clk);
        auxPorRst_n <= 1'b1;
        rst_n <= 1'b1;
    endtask
    // ========================================
    // tests
    initial begin
        for (int i = 0; i < 16; i++) begin
            readoutTable[i] = 8'h31 + 8'(i * 7);
            scaleTable[i] = 2'(i);
        end
        {fl, en, sel, st} = '0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        auxPorRst_n <= 1'b1;
        rchk("reset");
        for (int i = 0; i < 16; i++) begin
            sel = 4'(i);
            w(4'h2, wd(0, 0, 0));
            rchk("select");
        end
        $display("test select done");
        st = 2'h1;
        w(4'h1, wd(0, 0, 2'h1));
        rchk("d1");
        w(4'h1, wd(0, 0, 2'h2));
        rchk("d2 dropped");
        st = 2'h3;
        w(4'h1, wd(0, 0, 2'h3));
        rchk("d3hot");
        chk("clock stop", BUS_CLOCK_STOP, secondaryBusAction);
        chk("state out", STATE_D3HOT, power_state_field);
        @(posedge core_clk) busActionStrap <= 1'b0;
        #1 chk("off", BUS_POWER_OFF, secondaryBusAction);
        @(posedge core_clk) busCtlEnStrap <= 1'b0;
        #1 chk("on", BUS_ON, secondaryBusAction);
        @(posedge core_clk) busCtlEnStrap <= 1'b1;
        busActionStrap <= 1'b1;
        w(4'h1, wd(0, 0, 2'h0));
        n = 0;
        for (int i = 0; i < 4; i++) begin
            #1 n = n + internalResetPulse;
            @(posedge core_clk);
        end
        chk("int reset", 1, n);
        {st, sel} = '0;
        rchk("d0 back");
        $display("test state done");
        @(posedge core_clk) wakeRequest <= 1'b1;
        @(posedge core_clk) wakeRequest <= 1'b0;
        fl = 1;
        rchk("flag");
        chk("pin off", 0, wakePinDrive);
        en = 1;
        w(4'h2, wd(0, 1, 0));
        #1 chk("pin on", 1, wakePinDrive);
        fl = 0;
        w(4'h2, wd(1, 1, 0));
        #1 chk("pin clr", 0, wakePinDrive);
        @(posedge core_clk) wakeRequest <= 1'b1;
        @(posedge core_clk) wakeRequest <= 1'b0;
        fl = 1;
        st = 2'h3;
        w(4'h1, wd(0, 1, 2'h3));
        pulse_rst(0);
        st = 0;
        rchk("bus reset");
        pulse_rst(1);
        {fl, en} = '0;
        rchk("aux reset");
        w(4'h3, wd(1, 0, 0));
        rchk("os load");
        $display("test wake done");
        w(4'hc, 32'hffffffff);
        rchk("upper lanes");
        cfg_host_model_i.rd(8'h08, rdat);
        chk("unmapped", 0, rdat);
        $display("test lanes done");
        close_out();
    end
endmodule
